// ### inc/portmr_pkg.sv
package portmr_pkg;
  // Hold field
  localparam int unsigned HOLD_W = 7;
  localparam logic [6:0] HOLD_MAX = 7'h7f;
  localparam logic [6:0] HOLD_RST = 7'h18;
  // Slow ticks per hold unit
  localparam int unsigned UNIT_TICKS = 4096;
  localparam int unsigned UNIT_W = 12;
  // Pin selection field
  localparam int unsigned PSEL_W = 5;
  localparam int unsigned NPINS = 32;
  localparam logic [4:0] PSEL_OFF = 5'h00;
  // Low frequency clock: 32 kHz tick from 100 MHz
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned SLOW_HZ = 32000;
  localparam int unsigned SLOW_DIV = CLK_HZ / SLOW_HZ;
  localparam int unsigned DIV_W = 12;
  localparam int unsigned CNT_W = HOLD_W + UNIT_W;
  typedef enum logic [1:0] {
    PORTMR_RST_NONE,
    PORTMR_RST_HW,
    PORTMR_RST_POR
  } portmr_rst_e;
endpackage

// ### inc/portmr_sync_if.sv
interface portmr_sync_if;
  logic tick;
  logic pad_raw;
  logic gpio_raw;
  logic pad_s;
  logic gpio_s;
  modport src (output tick, output pad_raw, output gpio_raw, input pad_s, input gpio_s);
  modport snk (input tick, input pad_raw, input gpio_raw, output pad_s, output gpio_s);
endinterface

// ### tb/portmr_src.sv
// ======== Source model
module portmr_src (
  // Bench side and pins
  input logic clk,
  input logic pad_on,
  input logic gpio_on,
  input logic [4:0] pin_select,
  input logic polarity,
  output logic reset_pad,
  output logic [31:0] gpio_in = 32'h0
);
  timeunit 1ns / 1ns;
  int seed = 73220;
  assign reset_pad = pad_on;
  always @(posedge clk) begin
    gpio_in <= $random(seed);
    gpio_in[pin_select] <= gpio_on ~^ polarity;
  end
endmodule // portmr_src

// ### tb/portmr_top_asserts.sv
// ======== Checker
module portmr_top_asserts (
  // Watched ports
  input logic clk,
  input logic resetn,
  input logic reset_pad,
  input logic [4:0] pin_select,
  input logic polarity,
  input logic [6:0] hold,
  input logic low_freq_rc_oscillator_en,
  input logic por_pulse,
  input logic hw_reset_pulse,
  input logic [18:0] count
);
  timeunit 1ns / 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_osc; reset_pad || count != 0 |-> low_freq_rc_oscillator_en; endproperty
  a_osc: assert property (p_osc) else $error("osc off");
  property p_cnt; $changed(count) |-> count == 0 || count == $past(count) + 1; endproperty
  a_cnt: assert property (p_cnt) else $error("count step");
  property p_tck; $changed(count) |=> $stable(count) [*8]; endproperty
  a_tck: assert property (p_tck) else $error("count rate");
  property p_clr; hw_reset_pulse |=> pin_select == 0 && !polarity; endproperty
  a_clr: assert property (p_clr) else $error("pin kept");
  property p_por; por_pulse |=> hold == portmr_pkg::HOLD_RST && !por_pulse; endproperty
  a_por: assert property (p_por) else $error("hold kept");
  property p_h0; hold == 0 |-> !por_pulse; endproperty
  a_h0: assert property (p_h0) else $error("por at 0");
  property p_hw; hw_reset_pulse |-> !por_pulse ##1 !hw_reset_pulse; endproperty
  a_hw: assert property (p_hw) else $error("hw pulse");
  property p_cz; por_pulse |-> count != 0; endproperty
  a_cz: assert property (p_cz) else $error("por early");
  c_hw: cover property (hw_reset_pulse);
  c_run: cover property (count == 19'h4);
  c_pad: cover property (reset_pad && count != 0);
endmodule // portmr_top_asserts
bind portmr_top portmr_top_asserts u_chk (.*);

// ### tb/tb_top.sv
`define CHK(n, e, a) n_compared++; if ((a) !== (e)) begin err_count++; \
  $display("unexpected %s exp %h got %h", n, e, a); end
// ======== Testbench
module tb_top;
  timeunit 1ns / 1ns;
  import portmr_pkg::*;
  logic clk = 0, resetn = 0, cfg_we = 0, cfg_polarity = 0, osc_sw_enable = 0, sw_reset = 0;
  logic pad_on = 0, gpio_on = 0, reset_pad, polarity, por_pulse, hw_reset_pulse;
  logic low_freq_rc_oscillator_en;
  logic [4:0] cfg_pin_select = 0, pin_select;
  logic [6:0] cfg_hold = 0, hold;
  logic [31:0] gpio_in;
  logic [18:0] count;
  int seed = 73220, err_count = 0, n_compared = 0;
  always #5 clk = ~clk;
  portmr_src src (.*);
  portmr_top uut (.*);
  function automatic int ticks(int n);
    return n * SLOW_DIV + 9;
  endfunction
  task stop_test;
    if (err_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task drv(logic p, logic g, bit sel);
    @(posedge clk);
    cfg_we <= 0;
    pad_on <= p;
    gpio_on <= g;
    repeat (ticks(4)) begin
      @(negedge clk);
      if ((sel ? hw_reset_pulse : |count) === 1'b1) return;
    end
    err_count++;
    stop_test;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1;
    cfg_pin_select <= 5'($random(seed)) | 5'h01;
    cfg_polarity <= 1'($random(seed));
    cfg_we <= 1;
    @(negedge clk);
    `CHK("hold", HOLD_RST, hold)
    drv(0, 1, 0);
    `CHK("low_freq_rc_oscillator_en", 1'b1, low_freq_rc_oscillator_en)
    drv(1, 1, 0);
    repeat (ticks(1)) @(posedge clk);
    gpio_on <= 0;
    repeat (ticks(3)) @(negedge clk);
    `CHK("count", 1'b1, count >= 19'h4)
    drv(0, 0, 1);
    `CHK("por_pulse", 1'b0, por_pulse)
    repeat (2) @(negedge clk);
    `CHK("count", 19'h0, count)
    `CHK("pin_select", 5'h00, pin_select)
    `CHK("hold", 7'h00, hold)
    `CHK("polarity", 1'b0, polarity)
    `CHK("low_freq_rc_oscillator_en", 1'b0, low_freq_rc_oscillator_en)
    stop_test;
  end
endmodule // tb_top

// ### verilog/portmr_sync.sv
module portmr_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Source side
  portmr_sync_if.snk sif
);
  import portmr_pkg::*;
  logic [1:0] pad_q, pad_d, gpio_q, gpio_d;

  // ==========================================
  // Two stage sampling on the slow tick
  always_comb begin
    pad_d = pad_q;
    gpio_d = gpio_q;
    if (sif.tick) begin
      pad_d = {pad_q[0], sif.pad_raw};
      gpio_d = {gpio_q[0], sif.gpio_raw};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pad_q <= 2'h0;
      gpio_q <= 2'h0;
    end else begin
      pad_q <= pad_d;
      gpio_q <= gpio_d;
    end
  end

  assign sif.pad_s = pad_q[1];
  assign sif.gpio_s = gpio_q[1];
endmodule // portmr_sync

// ### verilog/portmr_top.sv
// Contract
// - The hold counter starts counting slow ticks once the asserted pad or enabled gpio source has passed the two stage synchroniser.
// - If all sources release before the threshold, the counter clears to zero with no POR.
// - Overlapping sources keep the count running as one continuous assertion.
// - The pin selection field is cleared by every reset type, software reprograms it.
// - The hold field returns to its default on a POR only, software reprograms it.
// - The threshold is the hold field times 4096 periods of the slow clock.
// - Pin selection zero disables the gpio source; polarity 0 is active low, 1 active high.
// - A pad pulse shorter than the threshold gives a hardware reset, longer gives a POR; with the hold field at zero every pad pulse gives a hardware reset.
// - A reset source forces the slow oscillator on even if software disabled it.
module portmr_top (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Reset sources
  input wire logic reset_pad,
  input wire logic [31:0] gpio_in,
  // Configuration written by software
  input wire logic cfg_we,
  input wire logic [portmr_pkg::PSEL_W-1:0] cfg_pin_select,
  input wire logic cfg_polarity,
  input wire logic [portmr_pkg::HOLD_W-1:0] cfg_hold,
  input wire logic osc_sw_enable,
  input wire logic sw_reset,
  // Status and reset outputs
  output logic [portmr_pkg::PSEL_W-1:0] pin_select,
  output logic polarity,
  output logic [portmr_pkg::HOLD_W-1:0] hold,
  output logic low_freq_rc_oscillator_en,
  output logic por_pulse,
  output logic hw_reset_pulse,
  output logic [portmr_pkg::CNT_W-1:0] count
);
  import portmr_pkg::*;

  function automatic logic gpio_active(input logic [NPINS-1:0] hits,
                                       input logic [PSEL_W-1:0] sel);
    gpio_active = (sel != PSEL_OFF) && hits[sel];
  endfunction

  // ==========================================
  // Per pin polarity match
  logic [NPINS-1:0] pin_match;
  for (genvar gi = 0; gi < NPINS; gi++) begin : g_match
    assign pin_match[gi] = (gpio_in[gi] == polarity);
  end

  // ==========================================
  // Slow clock divider
  logic [DIV_W-1:0] div_q, div_d;
  logic tick;
  logic src_any;
  always_comb begin
    div_d = div_q;
    tick = 1'b0;
    if (low_freq_rc_oscillator_en) begin
      if (div_q == DIV_W'(SLOW_DIV - 1)) begin
        div_d = '0;
        tick = 1'b1;
      end else begin
        div_d = div_q + 1'b1;
      end
    end
  end
  assign low_freq_rc_oscillator_en = osc_sw_enable | src_any | (count != '0);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

  // ==========================================
  // Source synchronisers
  portmr_sync_if sif ();
  assign sif.tick = tick;
  assign sif.pad_raw = reset_pad;
  assign sif.gpio_raw = gpio_active(pin_match, pin_select);
  portmr_sync u_sync (
    .clk(clk),
    .resetn(resetn),
    .sif(sif)
  );
  // Fast look at raw sources only drives the oscillator request
  assign src_any = reset_pad | sif.gpio_raw;

  // ==========================================
  // Configuration and counter
  logic [PSEL_W-1:0] psel_q, psel_d;
  logic pol_q, pol_d;
  logic [HOLD_W-1:0] hold_q, hold_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic fired_q, fired_d;
  logic pad_seen_q, pad_seen_d;
  logic por_q, por_d, hw_q, hw_d;
  logic asserted;
  logic [CNT_W-1:0] thresh;

  assign asserted = sif.pad_s | sif.gpio_s;
  assign thresh = {hold_q, UNIT_W'(0)};

  // ==========================================
  // Configuration fields, reset clear wins over a write
  always_comb begin
    psel_d = psel_q;
    pol_d = pol_q;
    hold_d = hold_q;
    if (cfg_we) begin
      psel_d = cfg_pin_select;
      pol_d = cfg_polarity;
      hold_d = cfg_hold;
    end
    if (por_q == 1'b1) begin
      hold_d = HOLD_RST;
    end
    if (sw_reset || hw_q || por_q) begin
      psel_d = PSEL_OFF;
      pol_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      psel_q <= PSEL_OFF;
      pol_q <= 1'b0;
      hold_q <= HOLD_RST;
    end else begin
      psel_q <= psel_d;
      pol_q <= pol_d;
      hold_q <= hold_d;
    end
  end

  // ==========================================
  // Hold counter and reset requests
  always_comb begin
    cnt_d = cnt_q;
    fired_d = fired_q;
    pad_seen_d = pad_seen_q;
    por_d = 1'b0;
    hw_d = 1'b0;
    if (tick) begin
      if (asserted) begin
        if (!fired_q) begin
          cnt_d = cnt_q + 1'b1;
          if (sif.pad_s) begin
            pad_seen_d = 1'b1;
          end
          if ((cnt_q + 1'b1) >= thresh && thresh != '0) begin
            por_d = 1'b1;
            fired_d = 1'b1;
          end
        end
      end else begin
        cnt_d = '0;
        fired_d = 1'b0;
        pad_seen_d = 1'b0;
        hw_d = pad_seen_q && !fired_q;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
      fired_q <= 1'b0;
      pad_seen_q <= 1'b0;
      por_q <= 1'b0;
      hw_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      fired_q <= fired_d;
      pad_seen_q <= pad_seen_d;
      por_q <= por_d;
      hw_q <= hw_d;
    end
  end

  assign pin_select = psel_q;
  assign polarity = pol_q;
  assign hold = hold_q;
  assign count = cnt_q;
  assign por_pulse = por_q;
  assign hw_reset_pulse = hw_q;
endmodule // portmr_top
